// ===== design/strap_cfg_pkg.sv
// Purpose: constants and carriers for the strap capture block
// Assumes: APB slave, 32-bit data, word-aligned registers
// Notes: offsets are byte addresses of aligned words
// Function
// - port-count strap low selects single port, high selects dual port
// - oscillator strap shown in bits 2:0 of device information
// - first interface strap pair shown in bits 5:4 of port one info
// - single port: first pair picks RS232, RS422, RS485; 11b unsupported
// - dual port without enable strap: first pair picks type of both ports
// - dual port with enable strap: second pair picks second port type
// - second interface strap pair shown in bits 5:4 of port two info
// - eight general pins: direction, output and input registers
// - toggle strap picks request-send, terminal-ready or enable outputs
// - drive EEPROM select, clock, data; sample EEPROM data on input
// - all transactions timed by the bus clock
// - reset input taken asynchronously on assert and release
// - interrupt request is level, active low, open drain
// - open-drain power event output requests a power change
// - dual port with enable strap: each port keeps its own line type
package strap_cfg_pkg;
   localparam logic [7:0] DEV_INFO_OFS = 8'h00;
   localparam logic [7:0] PORT0_INFO_OFS = 8'h04;
   localparam logic [7:0] PORT1_INFO_OFS = 8'h08;
   localparam logic [7:0] GP_DIR_OFS = 8'h0C;
   localparam logic [7:0] GP_OUT_OFS = 8'h10;
   localparam logic [7:0] GP_IN_OFS = 8'h14;
   localparam logic [7:0] EEPROM_OFS = 8'h18;
   localparam logic [7:0] EVENT_OFS = 8'h1C;
   // field positions
   localparam int OSC_LSB = 0;
   localparam int MODE_BIT = 3;
   localparam int ALLEN_BIT = 4;
   localparam int TOGGLE_LSB = 8;
   localparam int IF_LSB = 4;
   localparam int EE_SEL_BIT = 0;
   localparam int EE_CLK_BIT = 1;
   localparam int EE_DO_BIT = 2;
   localparam int EE_DI_BIT = 3;
   localparam int INT_BIT = 0;
   localparam int PME_BIT = 1;
   // cycles after reset release before the straps are taken
   localparam logic [1:0] CAPTURE_DELAY = 2'h2;
   localparam logic [7:0] GP_DIR_RESET = 8'h00;
   localparam logic [7:0] GP_OUT_RESET = 8'h00;

   typedef struct packed {
      logic portSel;
      logic allEn;
      logic [2:0] osc;
      logic [1:0] lineIf0;
      logic [1:0] lineIf1;
      logic [1:0] toggleSel;
   } strap_s;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_s;
endpackage : strap_cfg_pkg

// ===== design/strap_mode_config_capture.sv
// Purpose: capture board straps, report them over APB, run loose pins
// Assumes: straps and pins asynchronous; one clock core_clk
// Notes: one wait state on every APB access
`timescale 1ns/1ps
`default_nettype none
module strap_mode_config_capture #(
   parameter int GP_W = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register bus
   input wire strap_cfg_pkg::apb_req_s apbReq,
   output logic apbPready,
   output logic apbPslverr,
   output logic [31:0] apbPrdata,
   // board straps
   input wire strap_cfg_pkg::strap_s straps,
   // resolved configuration
   output logic dualPortMode,
   output logic [1:0] portType0,
   output logic [1:0] portType1,
   output logic [1:0] toggleSource,
   output logic [2:0] oscCode,
   // general pins
   input wire logic [GP_W-1:0] gpIn,
   output logic [GP_W-1:0] gpOut,
   output logic [GP_W-1:0] gpOe,
   // serial eeprom
   input wire logic eepromDataIn,
   output logic eepromSelect,
   output logic eepromSerialClock,
   output logic eepromDataOut,
   // open-drain requests
   output logic intOut,
   output logic intOe,
   output logic pmeOut,
   output logic pmeOe
);
   localparam int SYNC_W = $bits(strap_cfg_pkg::strap_s) + GP_W + 1;

   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      logic [SYNC_W-1:0] sync1;
      logic [SYNC_W-1:0] sync2;
      logic [1:0] capCnt;
      logic capDone;
      strap_cfg_pkg::strap_s cap;
      logic [1:0] type1;
      logic [GP_W-1:0] gpDir;
      logic [GP_W-1:0] gpOutReg;
      logic eeSel;
      logic eeClk;
      logic eeDo;
      logic intReq;
      logic pmeReq;
      strap_cfg_pkg::apb_rsp_s rsp;
   } state_s;

   state_s st;
   state_s next_st;
   strap_cfg_pkg::strap_s liveStraps;
   logic [GP_W-1:0] liveGp;
   logic liveEe;
   logic access;

   // ************************************************
   // decode
   // ************************************************
   function automatic logic isMapped(input logic [7:0] a);
      unique case (a)
         strap_cfg_pkg::DEV_INFO_OFS,
         strap_cfg_pkg::PORT0_INFO_OFS,
         strap_cfg_pkg::PORT1_INFO_OFS,
         strap_cfg_pkg::GP_DIR_OFS,
         strap_cfg_pkg::GP_OUT_OFS,
         strap_cfg_pkg::GP_IN_OFS,
         strap_cfg_pkg::EEPROM_OFS,
         strap_cfg_pkg::EVENT_OFS: isMapped = 1'b1;
         default: isMapped = 1'b0;
      endcase
   endfunction : isMapped

   function automatic logic [31:0] regRead(
      input logic [7:0] a,
      input state_s s,
      input logic [GP_W-1:0] gp,
      input logic ee
   );
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (a)
         strap_cfg_pkg::DEV_INFO_OFS: begin
            d[strap_cfg_pkg::OSC_LSB +: 3] = s.cap.osc;
            d[strap_cfg_pkg::MODE_BIT] = s.cap.portSel;
            d[strap_cfg_pkg::ALLEN_BIT] = s.cap.allEn;
            d[strap_cfg_pkg::TOGGLE_LSB +: 2] = s.cap.toggleSel;
         end
         strap_cfg_pkg::PORT0_INFO_OFS: begin
            d[strap_cfg_pkg::IF_LSB +: 2] = s.cap.lineIf0;
         end
         strap_cfg_pkg::PORT1_INFO_OFS: begin
            d[strap_cfg_pkg::IF_LSB +: 2] = s.cap.lineIf1;
         end
         strap_cfg_pkg::GP_DIR_OFS: d[GP_W-1:0] = s.gpDir;
         strap_cfg_pkg::GP_OUT_OFS: d[GP_W-1:0] = s.gpOutReg;
         strap_cfg_pkg::GP_IN_OFS: d[GP_W-1:0] = gp;
         strap_cfg_pkg::EEPROM_OFS: begin
            d[strap_cfg_pkg::EE_SEL_BIT] = s.eeSel;
            d[strap_cfg_pkg::EE_CLK_BIT] = s.eeClk;
            d[strap_cfg_pkg::EE_DO_BIT] = s.eeDo;
            d[strap_cfg_pkg::EE_DI_BIT] = ee;
         end
         strap_cfg_pkg::EVENT_OFS: begin
            d[strap_cfg_pkg::INT_BIT] = s.intReq;
            d[strap_cfg_pkg::PME_BIT] = s.pmeReq;
         end
         default: d = 32'h0000_0000;
      endcase
      regRead = d;
   endfunction : regRead

   // ************************************************
   // next state
   // ************************************************
   assign liveStraps = st.sync2[SYNC_W-1 -: $bits(strap_cfg_pkg::strap_s)];
   assign liveGp = st.sync2[GP_W:1];
   assign liveEe = st.sync2[0];
   assign access = apbReq.psel & apbReq.penable & ~st.rsp.pready;

   always_comb begin
      next_st = st;
      // pins are asynchronous, so two stages before any use
      next_st.sync1 = {straps, gpIn, eepromDataIn};
      next_st.sync2 = st.sync1;

      // take straps once the synchroniser has refilled after reset
      if (!st.capDone) begin
         if (st.capCnt == strap_cfg_pkg::CAPTURE_DELAY) begin
            next_st.capDone = 1'b1;
            next_st.cap = liveStraps;
            // second port follows its own pair only in full mode
            if (liveStraps.portSel && liveStraps.allEn) begin
               next_st.type1 = liveStraps.lineIf1;
            end else begin
               next_st.type1 = liveStraps.lineIf0;
            end
         end else begin
            next_st.capCnt = st.capCnt + 2'h1;
         end
      end

      // one wait state: answer in the second access cycle
      next_st.rsp.pready = access;
      next_st.rsp.pslverr = access & ~isMapped(apbReq.paddr);
      next_st.rsp.prdata = 32'h0000_0000;
      if (access && !apbReq.pwrite) begin
         next_st.rsp.prdata = regRead(apbReq.paddr, st, liveGp, liveEe);
      end

      if (access && apbReq.pwrite) begin
         unique case (apbReq.paddr)
            strap_cfg_pkg::GP_DIR_OFS: begin
               next_st.gpDir = apbReq.pwdata[GP_W-1:0];
            end
            strap_cfg_pkg::GP_OUT_OFS: begin
               next_st.gpOutReg = apbReq.pwdata[GP_W-1:0];
            end
            strap_cfg_pkg::EEPROM_OFS: begin
               next_st.eeSel = apbReq.pwdata[strap_cfg_pkg::EE_SEL_BIT];
               next_st.eeClk = apbReq.pwdata[strap_cfg_pkg::EE_CLK_BIT];
               next_st.eeDo = apbReq.pwdata[strap_cfg_pkg::EE_DO_BIT];
            end
            strap_cfg_pkg::EVENT_OFS: begin
               next_st.intReq = apbReq.pwdata[strap_cfg_pkg::INT_BIT];
               next_st.pmeReq = apbReq.pwdata[strap_cfg_pkg::PME_BIT];
            end
            default: begin
               next_st.intReq = st.intReq;
            end
         endcase
      end
   end

   // ************************************************
   // registers
   // ************************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.gpDir <= strap_cfg_pkg::GP_DIR_RESET;
         st.gpOutReg <= strap_cfg_pkg::GP_OUT_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************
   // outputs, all straight from flops except intOut and pmeOut, tied low
   // ************************************************
   assign apbPready = st.rsp.pready;
   assign apbPslverr = st.rsp.pslverr;
   assign apbPrdata = st.rsp.prdata;
   assign dualPortMode = st.cap.portSel;
   assign portType0 = st.cap.lineIf0;
   assign portType1 = st.type1;
   assign toggleSource = st.cap.toggleSel;
   assign oscCode = st.cap.osc;
   assign gpOut = st.gpOutReg;
   assign gpOe = st.gpDir;
   assign eepromSelect = st.eeSel;
   assign eepromSerialClock = st.eeClk;
   assign eepromDataOut = st.eeDo;
   // open drain: only ever pull low, enable carries the request
   assign intOut = 1'b0;
   assign intOe = st.intReq;
   assign pmeOut = 1'b0;
   assign pmeOe = st.pmeReq;

   // ************************************************
   // assertions
   // ************************************************
   property p_hold;
      @(posedge core_clk) disable iff (rst)
      st.capDone |=> $stable(st.cap) && st.capDone;
   endproperty
   a_hold: assert property (p_hold)
      else $error("captured straps changed");

   property p_capTime;
      @(posedge core_clk) disable iff (rst)
      $rose(st.capCnt == strap_cfg_pkg::CAPTURE_DELAY) |=> st.capDone;
   endproperty
   a_capTime: assert property (p_capTime)
      else $error("strap capture late");

   property p_mode;
      @(posedge core_clk) disable iff (rst)
      $rose(st.capDone) |-> dualPortMode == $past(liveStraps.portSel);
   endproperty
   a_mode: assert property (p_mode)
      else $error("port mode not from strap");

   property p_osc;
      @(posedge core_clk) disable iff (rst)
      access && !apbReq.pwrite &&
      apbReq.paddr == strap_cfg_pkg::DEV_INFO_OFS
      |=> apbPready && apbPrdata[2:0] == oscCode;
   endproperty
   a_osc: assert property (p_osc)
      else $error("oscillator code misread");

   property p_if0;
      @(posedge core_clk) disable iff (rst)
      access && !apbReq.pwrite &&
      apbReq.paddr == strap_cfg_pkg::PORT0_INFO_OFS
      |=> apbPrdata[5:4] == portType0 && apbPrdata[3:0] == 4'h0;
   endproperty
   a_if0: assert property (p_if0)
      else $error("port one info misread");

   property p_if1;
      @(posedge core_clk) disable iff (rst)
      access && !apbReq.pwrite &&
      apbReq.paddr == strap_cfg_pkg::PORT1_INFO_OFS
      |=> apbPrdata[5:4] == st.cap.lineIf1;
   endproperty
   a_if1: assert property (p_if1)
      else $error("port two info misread");

   property p_type1;
      @(posedge core_clk) disable iff (rst)
      st.capDone |-> portType1 ==
      ((st.cap.portSel && st.cap.allEn) ? st.cap.lineIf1 : portType0);
   endproperty
   a_type1: assert property (p_type1)
      else $error("second port type wrong");

   property p_gp;
      @(posedge core_clk) disable iff (rst)
      access && apbReq.pwrite &&
      apbReq.paddr == strap_cfg_pkg::GP_OUT_OFS
      |=> gpOut == $past(apbReq.pwdata[GP_W-1:0]);
   endproperty
   a_gp: assert property (p_gp)
      else $error("general output not written");

   property p_ee;
      @(posedge core_clk) disable iff (rst)
      access && apbReq.pwrite &&
      apbReq.paddr == strap_cfg_pkg::EEPROM_OFS
      |=> eepromSelect == $past(apbReq.pwdata[0]) &&
      eepromSerialClock == $past(apbReq.pwdata[1]);
   endproperty
   a_ee: assert property (p_ee)
      else $error("eeprom pins not written");

   property p_rdy;
      @(posedge core_clk) disable iff (rst)
      apbPready |-> $past(access) ##1 !apbPready;
   endproperty
   a_rdy: assert property (p_rdy)
      else $error("ready longer than one cycle");

   property p_int;
      @(posedge core_clk) disable iff (rst)
      access && apbReq.pwrite &&
      apbReq.paddr == strap_cfg_pkg::EVENT_OFS
      |=> intOe == $past(apbReq.pwdata[0]) && !intOut &&
      pmeOe == $past(apbReq.pwdata[1]);
   endproperty
   a_int: assert property (p_int)
      else $error("request pins not written");

   property p_tog;
      @(posedge core_clk) disable iff (rst)
      access && !apbReq.pwrite &&
      apbReq.paddr == strap_cfg_pkg::DEV_INFO_OFS
      |=> apbPrdata[9:8] == toggleSource;
   endproperty
   a_tog: assert property (p_tog)
      else $error("toggle source misread");

   property p_err;
      @(posedge core_clk) disable iff (rst)
      access && !isMapped(apbReq.paddr)
      |=> apbPslverr && apbPrdata == 32'h0000_0000;
   endproperty
   a_err: assert property (p_err)
      else $error("unmapped access not refused");

   property p_gpDir;
      @(posedge core_clk) disable iff (rst)
      access && apbReq.pwrite &&
      apbReq.paddr == strap_cfg_pkg::GP_DIR_OFS
      |=> gpOe == $past(apbReq.pwdata[GP_W-1:0]);
   endproperty
   a_gpDir: assert property (p_gpDir)
      else $error("general direction not written");

   property p_gpIn;
      @(posedge core_clk) disable iff (rst)
      access && !apbReq.pwrite &&
      apbReq.paddr == strap_cfg_pkg::GP_IN_OFS
      |=> apbPrdata[GP_W-1:0] == $past(liveGp);
   endproperty
   a_gpIn: assert property (p_gpIn)
      else $error("general input misread");

   // reserved codes must come through untouched, not be mapped away
   property p_capSrc;
      @(posedge core_clk) disable iff (rst)
      $rose(st.capDone) |-> oscCode == $past(liveStraps.osc) &&
      portType0 == $past(liveStraps.lineIf0) &&
      toggleSource == $past(liveStraps.toggleSel);
   endproperty
   a_capSrc: assert property (p_capSrc)
      else $error("straps not passed unchanged");

endmodule : strap_mode_config_capture
`default_nettype wire

// ===== sim/board_model.sv
// Purpose: board side of the strap block: straps, loose pins, eeprom
// Assumes: eeprom data line has a pull-up; idle pins show a fixed pattern
// Notes: the strap set is chosen by a small index from the bench
`timescale 1ns/1ps
`default_nettype none
module board_model (
   // strap choice
   input wire logic [2:0] sel,
   output var strap_cfg_pkg::strap_s straps,
   // general pins
   input wire logic [7:0] gpOut,
   input wire logic [7:0] gpOe,
   output logic [7:0] gpPin,
   // serial eeprom
   input wire logic eeSel,
   input wire logic eeClk,
   output logic eeDo
);
   // ****************************************
   // straps and wires
   // ****************************************
   logic [7:0] shreg = 8'h96;
   always_comb begin
      straps.portSel = sel[0];
      straps.allEn = sel[1];
      // codes 6 and 7 too, to see that reserved values pass unchanged
      straps.osc = sel;
      straps.lineIf0 = sel[1:0];
      straps.lineIf1 = ~sel[1:0];
      straps.toggleSel = sel[2:1];
   end
   assign gpPin = (gpOut & gpOe) | (8'hA5 & ~gpOe);
   always @(posedge eeClk) begin
      if (eeSel) shreg <= {shreg[6:0], shreg[7]};
   end
   // a released data line rises through the pull-up
   assign eeDo = eeSel ? shreg[7] : 1'b1;
endmodule : board_model
`default_nettype wire

// ===== sim/strap_mode_config_capture_tb.sv
// Purpose: self-checking bench for the strap capture block
// Assumes: one wait state per bus access, straps taken after release
// Notes: every scenario is its own task
`timescale 1ns/1ps
`default_nettype none
module strap_mode_config_capture_tb;
   // ****************************************
   // signals and instances
   // ****************************************
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   strap_cfg_pkg::apb_req_s apbReq = '0;
   strap_cfg_pkg::strap_s straps;
   logic apbPready, apbPslverr, dualPortMode, err, eeIn, eeSel, eeClk;
   logic eeOut, intOut, intOe, pmeOut, pmeOe;
   logic [31:0] apbPrdata, rd;
   logic [1:0] portType0, portType1, toggleSource;
   logic [2:0] oscCode;
   logic [2:0] sel = 3'h0;
   logic [7:0] gpIn, gpOut, gpOe;
   int mismatches = 0;
   int num_checks = 0;

   strap_mode_config_capture uut (.core_clk(core_clk), .rst(rst),
      .apbReq(apbReq), .apbPready(apbPready), .apbPslverr(apbPslverr),
      .apbPrdata(apbPrdata), .straps(straps), .dualPortMode(dualPortMode),
      .portType0(portType0), .portType1(portType1),
      .toggleSource(toggleSource), .oscCode(oscCode), .gpIn(gpIn),
      .gpOut(gpOut), .gpOe(gpOe), .eepromDataIn(eeIn),
      .eepromSelect(eeSel), .eepromSerialClock(eeClk),
      .eepromDataOut(eeOut), .intOut(intOut), .intOe(intOe),
      .pmeOut(pmeOut), .pmeOe(pmeOe));
   board_model board (.sel(sel), .straps(straps), .gpOut(gpOut),
      .gpOe(gpOe), .gpPin(gpIn), .eeSel(eeSel), .eeClk(eeClk), .eeDo(eeIn));

   initial begin
      forever #4 core_clk = ~core_clk;
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task wrap_up;
      if (mismatches == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      apbReq.psel <= 1'b1;
      apbReq.pwrite <= wr;
      apbReq.paddr <= a;
      apbReq.pwdata <= d;
      @(posedge core_clk);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (apbPready !== 1'b1 && n < 20);
      if (n >= 20) mismatches++;
      rd = apbPrdata;
      err = apbPslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb

   task do_reset;
      rst <= 1'b1;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      repeat (5) @(posedge core_clk);
   endtask : do_reset

   // ****************************************
   // scenarios
   // ****************************************
   task t_straps;
      logic [2:0] s;
      logic [1:0] p1;
      logic [1:0] q;
      for (int i = 0; i < 8; i++) begin
         s = 3'(i);
         q = ~s[1:0];
         p1 = (s[0] & s[1]) ? q : s[1:0];
         sel <= s;
         do_reset;
         #1;
         chk(32'(dualPortMode), 32'(s[0]));
         chk(32'(oscCode), 32'(s));
         chk(32'(portType0), 32'(s[1:0]));
         chk(32'(portType1), 32'(p1));
         chk(32'(toggleSource), 32'(s[2:1]));
         @(posedge core_clk);
         apb(1'b0, strap_cfg_pkg::DEV_INFO_OFS, '0);
         chk(rd, (32'(s[2:1]) << strap_cfg_pkg::TOGGLE_LSB) |
            (32'(s[1]) << strap_cfg_pkg::ALLEN_BIT) |
            (32'(s[0]) << strap_cfg_pkg::MODE_BIT) | 32'(s));
         apb(1'b0, strap_cfg_pkg::PORT0_INFO_OFS, '0);
         chk(rd, 32'(s[1:0]) << strap_cfg_pkg::IF_LSB);
         apb(1'b0, strap_cfg_pkg::PORT1_INFO_OFS, '0);
         chk(rd, 32'(q) << strap_cfg_pkg::IF_LSB);
         sel <= ~s;
         repeat (4) @(posedge core_clk);
         chk(32'(oscCode), 32'(s));
      end
   endtask : t_straps

   task t_gpio;
      apb(1'b1, strap_cfg_pkg::GP_DIR_OFS, 32'h000000F0);
      apb(1'b1, strap_cfg_pkg::GP_OUT_OFS, 32'h0000003C);
      chk(32'(gpOe), 32'h000000F0);
      chk(32'(gpOut), 32'h0000003C);
      apb(1'b1, strap_cfg_pkg::GP_IN_OFS, 32'h000000FF);
      apb(1'b0, strap_cfg_pkg::GP_IN_OFS, '0);
      chk(rd, 32'h00000035);
   endtask : t_gpio

   task t_eeprom;
      apb(1'b1, strap_cfg_pkg::EEPROM_OFS, 32'h00000005);
      chk(32'({eeOut, eeClk, eeSel}), 32'h00000005);
      apb(1'b0, strap_cfg_pkg::EEPROM_OFS, '0);
      chk(32'(rd[3]), 32'h00000001);
      apb(1'b1, strap_cfg_pkg::EEPROM_OFS, 32'h00000003);
      apb(1'b0, strap_cfg_pkg::EEPROM_OFS, '0);
      chk(32'(rd[3]), 32'h00000000);
      apb(1'b1, strap_cfg_pkg::EEPROM_OFS, 32'h00000000);
      apb(1'b0, strap_cfg_pkg::EEPROM_OFS, '0);
      chk(32'(rd[3]), 32'h00000001);
   endtask : t_eeprom

   task t_event;
      apb(1'b1, strap_cfg_pkg::EVENT_OFS, 32'h00000003);
      chk(32'({intOe, pmeOe}), 32'h00000003);
      chk(32'({intOut, pmeOut}), 32'h00000000);
      // reset taken between edges must clear at once
      rst <= 1'b1;
      #1;
      chk(32'({intOe, pmeOe, gpOe}), 32'h00000000);
      do_reset;
   endtask : t_event

   task t_bus;
      apb(1'b0, 8'h20, '0);
      chk(32'(err), 32'h00000001);
      chk(rd, 32'h00000000);
      apb(1'b1, strap_cfg_pkg::DEV_INFO_OFS, 32'hFFFFFFFF);
      chk(32'(err), 32'h00000000);
      apb(1'b0, strap_cfg_pkg::DEV_INFO_OFS, '0);
      chk(rd, 32'h00000000);
   endtask : t_bus

   initial begin
      do_reset;
      t_straps;
      t_gpio;
      t_eeprom;
      t_event;
      t_bus;
      wrap_up;
   end

   initial begin
      #20000;
      mismatches++;
      wrap_up;
   end
endmodule : strap_mode_config_capture_tb
`default_nettype wire
